// ---- rtl/adpbs_map.vh ----
`ifndef ADPBS_MAP_VH
`define ADPBS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADPBS_OFF_CTRL 12'h000
`define ADPBS_OFF_DAC 12'h004
`define ADPBS_OFF_STATUS 12'h008
`define ADPBS_OFF_RATIO 12'h00c
`define ADPBS_OFF_MADDR 12'h010
`define ADPBS_OFF_MDATA 12'h014

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ADPBS_CTRL_ADM_BIT 4
`define ADPBS_CTRL_DAM_BIT 3
`define ADPBS_CTRL_CR_BIT 2
`define ADPBS_CTRL_RST 3'h0
`define ADPBS_DAC_RST 2'h0
`define ADPBS_ST_READY_BIT 0
`define ADPBS_ST_RATIO_LSB 1
`define ADPBS_ST_PHASE_LSB 3
`define ADPBS_MSEL_LSB 9
`define ADPBS_MADDR_RST 11'h000

// ----------------------------------------
// Memory selects and geometry
// ----------------------------------------
`define ADPBS_MSEL_PROG 2'h0
`define ADPBS_MSEL_PARAM 2'h1
`define ADPBS_MSEL_DATA 2'h2
`define ADPBS_MEM_LAST 9'h1ff

// ----------------------------------------
// Clock ratio decode
// ----------------------------------------
`define ADPBS_RATIO_00 16'h0040
`define ADPBS_RATIO_01 16'h0100
`define ADPBS_RATIO_10 16'h0180
`define ADPBS_RATIO_11 16'h0200

// ----------------------------------------
// Timing
// ----------------------------------------
`define ADPBS_PLL_WAIT 19'h40000
`define ADPBS_BOOT_NS 42000
`define ADPBS_CLK_NS 25

// ----------------------------------------
// Boot program encoding
// ----------------------------------------
`define ADPBS_OP_MOVE 8'h01
`define ADPBS_SRC_IN0 8'h01
`define ADPBS_SRC_IN1 8'h02
`define ADPBS_SRC_ADC0 8'h03
`define ADPBS_SRC_ADC1 8'h04
`define ADPBS_DST_DAC0 8'h10
`define ADPBS_DST_DAC1 8'h11
`define ADPBS_DST_DAC2 8'h12
`define ADPBS_DST_DAC3 8'h13
`define ADPBS_DST_OUT0 8'h20
`define ADPBS_DST_OUT1 8'h21

`endif

// ---- rtl/adpbs_mem.v ----
`timescale 1ns/1ps
`include "adpbs_map.vh"

module adpbs_mem (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire start_in,
    output reg done_out,
    input wire wr_in,
    input wire [1:0] sel_in,
    input wire [8:0] addr_in,
    input wire [31:0] wdata_in,
    output reg [31:0] rdata_out
);

    reg [31:0] prog_mem [0:511];
    reg [31:0] param_mem [0:511];
    reg [31:0] data_mem [0:511];
    reg walk_reg;
    reg [8:0] walk_addr_reg;

    // ----------------------------------------
    // Built-in pass-through program
    // ----------------------------------------
    function [31:0] rom_word;
        input [8:0] a;
        begin
            case (a)
                9'h000: rom_word = {`ADPBS_OP_MOVE, `ADPBS_SRC_IN0, `ADPBS_DST_DAC0, 8'h00};
                9'h001: rom_word = {`ADPBS_OP_MOVE, `ADPBS_SRC_IN1, `ADPBS_DST_DAC1, 8'h00};
                9'h002: rom_word = {`ADPBS_OP_MOVE, `ADPBS_SRC_IN0, `ADPBS_DST_OUT0, 8'h00};
                9'h003: rom_word = {`ADPBS_OP_MOVE, `ADPBS_SRC_IN1, `ADPBS_DST_OUT1, 8'h00};
                9'h004: rom_word = {`ADPBS_OP_MOVE, `ADPBS_SRC_ADC0, `ADPBS_DST_DAC2, 8'h00};
                9'h005: rom_word = {`ADPBS_OP_MOVE, `ADPBS_SRC_ADC1, `ADPBS_DST_DAC3, 8'h00};
                default: rom_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Walker
    // ----------------------------------------
    always @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            walk_reg <= 1'b0;
            walk_addr_reg <= 9'h000;
            done_out <= 1'b0;
        end
        else if (ce_in)
        begin
            done_out <= 1'b0;
            if (start_in)
            begin
                walk_reg <= 1'b1;
                walk_addr_reg <= 9'h000;
            end
            else if (walk_reg)
            begin
                walk_addr_reg <= walk_addr_reg + 9'h001;
                if (walk_addr_reg == `ADPBS_MEM_LAST)
                begin
                    walk_reg <= 1'b0;
                    done_out <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Arrays
    // ----------------------------------------
    always @(posedge clk_in)
    begin
        if (ce_in)
        begin
            if (walk_reg)
            begin
                prog_mem[walk_addr_reg] <= rom_word(walk_addr_reg);
                param_mem[walk_addr_reg] <= 32'h0000_0000;
                data_mem[walk_addr_reg] <= 32'h0000_0000;
            end
            else if (wr_in)
            begin
                case (sel_in)
                    `ADPBS_MSEL_PROG: prog_mem[addr_in] <= wdata_in;
                    `ADPBS_MSEL_PARAM: param_mem[addr_in] <= wdata_in;
                    `ADPBS_MSEL_DATA: data_mem[addr_in] <= wdata_in;
                    default: ;
                endcase
            end
        end
    end

    always @*
    begin
        case (sel_in)
            `ADPBS_MSEL_PROG: rdata_out = prog_mem[addr_in];
            `ADPBS_MSEL_PARAM: rdata_out = param_mem[addr_in];
            `ADPBS_MSEL_DATA: rdata_out = data_mem[addr_in];
            default: rdata_out = 32'h0000_0000;
        endcase
    end

endmodule // adpbs_mem

// ---- rtl/adpbs_top.v ----
`timescale 1ns/1ps
`include "adpbs_map.vh"

module adpbs_top #(
    parameter [18:0] PLL_WAIT_CYCLES = `ADPBS_PLL_WAIT
) (
    input wire CLK_IN,
    input wire RST_IN,
    input wire CE_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire CLOCK_RATIO_SEL_LO_IN,
    input wire CLOCK_RATIO_SEL_HI_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    output reg INIT_DONE_OUT,
    output reg ADC_MUTE_N_OUT,
    output reg DAC_MUTE_N_OUT,
    output reg CLEAR_REGS_N_OUT,
    output reg [1:0] DAC_SETUP_FIELD_OUT,
    output reg [1:0] CLOCK_RATIO_OUT,
    output reg [1:0] SEQ_STATE_OUT
);

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam [1:0] S_LATCH = 2'h0;
    localparam [1:0] S_PLL = 2'h1;
    localparam [1:0] S_BOOT = 2'h2;
    localparam [1:0] S_READY = 2'h3;
    localparam integer BOOT_CYC_I = `ADPBS_BOOT_NS / `ADPBS_CLK_NS;
    localparam [10:0] BOOT_CYCLES = BOOT_CYC_I[10:0];
    localparam [18:0] PLL_LAST = PLL_WAIT_CYCLES - 19'h00001;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [18:0] pll_cnt_reg;
    reg [18:0] pll_cnt_next;
    reg [10:0] boot_cnt_reg;
    reg [10:0] boot_cnt_next;
    reg walk_done_reg;
    reg walk_done_next;
    reg start_walk_reg;
    reg start_walk_next;
    reg [1:0] ratio_reg;
    reg [1:0] ratio_next;
    reg [2:0] ctrl_reg;
    reg [2:0] ctrl_next;
    reg [1:0] dac_reg;
    reg [1:0] dac_next;
    reg [10:0] maddr_reg;
    reg [10:0] maddr_next;
    reg [31:0] prdata_next;
    reg pready_next;
    reg pslverr_next;
    reg mem_wr;
    reg rd_ok;
    reg wr_ok;
    reg [31:0] rd_val;
    wire access;
    wire finish;
    wire walk_done;
    wire [31:0] mem_rdata;
    wire [1:0] msel;
    wire ready;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [15:0] ratio_mult;
        input [1:0] code;
        begin
            case (code)
                2'h0: ratio_mult = `ADPBS_RATIO_00;
                2'h1: ratio_mult = `ADPBS_RATIO_01;
                2'h2: ratio_mult = `ADPBS_RATIO_10;
                default: ratio_mult = `ADPBS_RATIO_11;
            endcase
        end
    endfunction

    function is_mem_ok;
        input [1:0] sel;
        input clr_n;
        begin
            case (sel)
                `ADPBS_MSEL_PROG: is_mem_ok = 1'b1;
                `ADPBS_MSEL_PARAM: is_mem_ok = 1'b1;
                `ADPBS_MSEL_DATA: is_mem_ok = clr_n;
                default: is_mem_ok = 1'b0;
            endcase
        end
    endfunction

    assign access = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
    assign finish = PSEL_IN & PENABLE_IN & PREADY_OUT;
    assign msel = maddr_reg[10:`ADPBS_MSEL_LSB];
    assign ready = (state_reg == S_READY);

    // ----------------------------------------
    // Reset release on falling edge
    // ----------------------------------------
    // Both flops set at once; release walks through two falling edges
    always @(negedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end
        else if (CE_IN)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // Memory engine
    // ----------------------------------------
    adpbs_mem u_mem (
        .clk_in(CLK_IN),
        .rst_in(rst_sync_reg),
        .ce_in(CE_IN),
        .start_in(start_walk_reg),
        .done_out(walk_done),
        .wr_in(mem_wr),
        .sel_in(msel),
        .addr_in(maddr_reg[8:0]),
        .wdata_in(PWDATA_IN),
        .rdata_out(mem_rdata)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @*
    begin
        state_next = state_reg;
        pll_cnt_next = pll_cnt_reg;
        boot_cnt_next = boot_cnt_reg;
        walk_done_next = walk_done_reg | walk_done;
        start_walk_next = 1'b0;
        ratio_next = ratio_reg;
        case (state_reg)
            S_LATCH:
            begin
                // Pins are only meaningful here; later changes are ignored
                ratio_next = {CLOCK_RATIO_SEL_LO_IN, CLOCK_RATIO_SEL_HI_IN};
                pll_cnt_next = 19'h00001;
                state_next = S_PLL;
            end
            S_PLL:
            begin
                if (pll_cnt_reg >= PLL_LAST)
                begin
                    state_next = S_BOOT;
                    boot_cnt_next = 11'h000;
                    walk_done_next = 1'b0;
                    start_walk_next = 1'b1;
                end
                else
                begin
                    pll_cnt_next = pll_cnt_reg + 19'h00001;
                end
            end
            S_BOOT:
            begin
                if (boot_cnt_reg != BOOT_CYCLES)
                begin
                    boot_cnt_next = boot_cnt_reg + 11'h001;
                end
                // Boot ends only after both the copy and the fixed interval
                if (boot_cnt_reg == BOOT_CYCLES && walk_done_reg)
                begin
                    state_next = S_READY;
                end
            end
            S_READY:
            begin
                state_next = S_READY;
            end
            default:
            begin
                state_next = S_LATCH;
            end
        endcase
    end

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    always @*
    begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (PADDR_IN)
            `ADPBS_OFF_CTRL:
            begin
                rd_val[`ADPBS_CTRL_ADM_BIT] = ctrl_reg[2];
                rd_val[`ADPBS_CTRL_DAM_BIT] = ctrl_reg[1];
                rd_val[`ADPBS_CTRL_CR_BIT] = ctrl_reg[0];
            end
            `ADPBS_OFF_DAC: rd_val[1:0] = dac_reg;
            `ADPBS_OFF_STATUS:
            begin
                rd_val[`ADPBS_ST_READY_BIT] = ready;
                rd_val[`ADPBS_ST_RATIO_LSB + 1:`ADPBS_ST_RATIO_LSB] = ratio_reg;
                rd_val[`ADPBS_ST_PHASE_LSB + 1:`ADPBS_ST_PHASE_LSB] = state_reg;
            end
            `ADPBS_OFF_RATIO: rd_val[15:0] = ratio_mult(ratio_reg);
            `ADPBS_OFF_MADDR: rd_val[10:0] = maddr_reg;
            `ADPBS_OFF_MDATA:
            begin
                rd_ok = is_mem_ok(msel, ctrl_reg[0]);
                rd_val = rd_ok ? mem_rdata : 32'h0000_0000;
            end
            default: rd_ok = 1'b0;
        endcase
        // Only status is answered while booting
        if (!ready && PADDR_IN != `ADPBS_OFF_STATUS)
        begin
            rd_ok = 1'b0;
            rd_val = 32'h0000_0000;
        end
    end

    always @*
    begin
        case (PADDR_IN)
            `ADPBS_OFF_CTRL: wr_ok = ready;
            `ADPBS_OFF_DAC: wr_ok = ready;
            `ADPBS_OFF_MADDR: wr_ok = ready;
            `ADPBS_OFF_MDATA: wr_ok = ready & is_mem_ok(msel, ctrl_reg[0]);
            default: wr_ok = 1'b0;
        endcase
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    always @*
    begin
        pready_next = access;
        pslverr_next = 1'b0;
        prdata_next = PRDATA_OUT;
        ctrl_next = ctrl_reg;
        dac_next = dac_reg;
        maddr_next = maddr_reg;
        mem_wr = 1'b0;
        if (access)
        begin
            // Read data captured one edge before completion
            prdata_next = PWRITE_IN ? 32'h0000_0000 : rd_val;
            pslverr_next = PWRITE_IN ? ~wr_ok : ~rd_ok;
        end
        if (finish && PWRITE_IN && wr_ok)
        begin
            case (PADDR_IN)
                `ADPBS_OFF_CTRL:
                begin
                    ctrl_next = {PWDATA_IN[`ADPBS_CTRL_ADM_BIT], PWDATA_IN[`ADPBS_CTRL_DAM_BIT],
                        PWDATA_IN[`ADPBS_CTRL_CR_BIT]};
                end
                `ADPBS_OFF_DAC: dac_next = PWDATA_IN[1:0];
                `ADPBS_OFF_MADDR: maddr_next = PWDATA_IN[10:0];
                `ADPBS_OFF_MDATA:
                begin
                    mem_wr = 1'b1;
                    maddr_next = {maddr_reg[10:9], maddr_reg[8:0] + 9'h001};
                end
                default: ;
            endcase
        end
        else if (finish && !PWRITE_IN && rd_ok && PADDR_IN == `ADPBS_OFF_MDATA)
        begin
            // Auto-increment gives burst reads
            maddr_next = {maddr_reg[10:9], maddr_reg[8:0] + 9'h001};
        end
        if (start_walk_reg)
        begin
            ctrl_next = `ADPBS_CTRL_RST;
            dac_next = `ADPBS_DAC_RST;
            maddr_next = `ADPBS_MADDR_RST;
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always @(posedge CLK_IN or posedge rst_sync_reg)
    begin
        if (rst_sync_reg)
        begin
            state_reg <= S_LATCH;
            pll_cnt_reg <= 19'h00000;
            boot_cnt_reg <= 11'h000;
            walk_done_reg <= 1'b0;
            start_walk_reg <= 1'b0;
            ratio_reg <= 2'h0;
            ctrl_reg <= `ADPBS_CTRL_RST;
            dac_reg <= `ADPBS_DAC_RST;
            maddr_reg <= `ADPBS_MADDR_RST;
            PRDATA_OUT <= 32'h0000_0000;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            INIT_DONE_OUT <= 1'b0;
            ADC_MUTE_N_OUT <= 1'b0;
            DAC_MUTE_N_OUT <= 1'b0;
            CLEAR_REGS_N_OUT <= 1'b0;
            DAC_SETUP_FIELD_OUT <= 2'h0;
            CLOCK_RATIO_OUT <= 2'h0;
            SEQ_STATE_OUT <= S_LATCH;
        end
        else if (CE_IN)
        begin
            state_reg <= state_next;
            pll_cnt_reg <= pll_cnt_next;
            boot_cnt_reg <= boot_cnt_next;
            walk_done_reg <= walk_done_next;
            start_walk_reg <= start_walk_next;
            ratio_reg <= ratio_next;
            ctrl_reg <= ctrl_next;
            dac_reg <= dac_next;
            maddr_reg <= maddr_next;
            PRDATA_OUT <= prdata_next;
            PREADY_OUT <= pready_next;
            PSLVERR_OUT <= pslverr_next;
            INIT_DONE_OUT <= (state_next == S_READY);
            ADC_MUTE_N_OUT <= ctrl_next[2];
            DAC_MUTE_N_OUT <= ctrl_next[1];
            CLEAR_REGS_N_OUT <= ctrl_next[0];
            DAC_SETUP_FIELD_OUT <= dac_next;
            CLOCK_RATIO_OUT <= ratio_next;
            SEQ_STATE_OUT <= state_next;
        end
    end

endmodule // adpbs_top

// ---- bench/adpbs_chk_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Sequencer and control port checks
// ----------------------------------------
module adpbs_chk #(
    parameter [18:0] PLL_WAIT_CYCLES = 19'h10
) (
    input wire CLK_IN,
    input wire RST_IN,
    input wire CE_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire CLOCK_RATIO_SEL_LO_IN,
    input wire CLOCK_RATIO_SEL_HI_IN,
    input wire [31:0] PRDATA_OUT,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    input wire INIT_DONE_OUT,
    input wire ADC_MUTE_N_OUT,
    input wire DAC_MUTE_N_OUT,
    input wire CLEAR_REGS_N_OUT,
    input wire [1:0] DAC_SETUP_FIELD_OUT,
    input wire [1:0] CLOCK_RATIO_OUT,
    input wire [1:0] SEQ_STATE_OUT
);
    reg [18:0] pll_cnt_reg;
    reg [11:0] boot_cnt_reg;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Phase lengths in enabled cycles, as the sequencer counts them
    always @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            pll_cnt_reg <= 19'h0;
            boot_cnt_reg <= 12'h0;
        end
        else if (CE_IN)
        begin
            pll_cnt_reg <= (SEQ_STATE_OUT == 2'h1) ? pll_cnt_reg + 19'h1 : 19'h0;
            boot_cnt_reg <= (SEQ_STATE_OUT == 2'h2) ? boot_cnt_reg + 12'h1 : 12'h0;
        end
    end
    a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    a_ready_answer: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
        else $error("no answer after one wait");
    a_early_refused: assert property (PREADY_OUT && !INIT_DONE_OUT && $past(PADDR_IN) != 12'h008
        |-> PSLVERR_OUT)
        else $error("early access not refused");
    a_unmute_cause: assert property ($rose(ADC_MUTE_N_OUT) || $rose(DAC_MUTE_N_OUT)
        |-> $past(PSEL_IN && PWRITE_IN && PADDR_IN == 12'h000)
        || $past(PSEL_IN && PWRITE_IN && PADDR_IN == 12'h000, 2))
        else $error("unmute without control write");
    a_ratio_latch: assert property (SEQ_STATE_OUT == 2'h1 && $past(SEQ_STATE_OUT) == 2'h0
        |-> CLOCK_RATIO_OUT == $past({CLOCK_RATIO_SEL_LO_IN, CLOCK_RATIO_SEL_HI_IN}))
        else $error("ratio code not latched");
    a_ratio_hold: assert property (SEQ_STATE_OUT != 2'h0 && $past(SEQ_STATE_OUT) != 2'h0
        |-> $stable(CLOCK_RATIO_OUT))
        else $error("ratio code moved");
    a_pll_length: assert property (SEQ_STATE_OUT == 2'h2 && $past(SEQ_STATE_OUT) == 2'h1
        |-> pll_cnt_reg >= PLL_WAIT_CYCLES - 19'h1 && pll_cnt_reg <= PLL_WAIT_CYCLES)
        else $error("pll wait length wrong");
    a_boot_length: assert property (SEQ_STATE_OUT == 2'h3 && $past(SEQ_STATE_OUT) == 2'h2
        |-> boot_cnt_reg >= 12'h68f && boot_cnt_reg <= 12'h898)
        else $error("boot length wrong");
    a_muted_at_ready: assert property ($rose(INIT_DONE_OUT) |-> !ADC_MUTE_N_OUT && !DAC_MUTE_N_OUT
        && !CLEAR_REGS_N_OUT && DAC_SETUP_FIELD_OUT == 2'h0)
        else $error("not cleared at ready");
endmodule // adpbs_chk

// ---- bench/adpbs_host.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Host on the control port
// ----------------------------------------
module adpbs_host (
    input wire clk_in,
    input wire [31:0] prdata_in,
    input wire pready_in,
    input wire pslverr_in,
    output reg psel_out,
    output reg penable_out,
    output reg pwrite_out,
    output reg [11:0] paddr_out,
    output reg [31:0] pwdata_out,
    output reg ratio_lo_out,
    output reg ratio_hi_out
);
    initial
    begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h0;
        pwdata_out = 32'h0;
        ratio_lo_out = 1'b0;
        ratio_hi_out = 1'b0;
    end
    // Pins move while reset is held, else clicks; t_init also moves them once while running
    task set_ratio(input [1:0] code);
    begin
        ratio_lo_out <= code[1];
        ratio_hi_out <= code[0];
    end
    endtask
    // Leading edge keeps release and next setup apart
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] rd, output err, output ok);
        integer i;
    begin
        @(posedge clk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        ok = 1'b0;
        for (i = 0; i < 20 && !ok; i = i + 1)
        begin
            @(posedge clk_in);
            ok = pready_in;
        end
        rd = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        pwrite_out <= ~w;
        paddr_out <= ~a;
        pwdata_out <= ~d;
    end
    endtask
    // Called only after ready; skips program load for pass-through
    task bring_up(output ok);
        reg [31:0] rd;
        reg err;
        reg ok1;
    begin
        xfer(1'b1, 12'h000, 32'h1c, rd, err, ok1);
        xfer(1'b1, 12'h004, 32'h1, rd, err, ok);
        ok = ok & ok1;
    end
    endtask
endmodule // adpbs_host

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_top;
    localparam [18:0] PLL_WAIT_CYCLES = 19'h10;
    localparam [223:0] BOOT = {32'h0, 32'h01041300, 32'h01031200, 32'h01022100,
        32'h01012000, 32'h01021100, 32'h01011000};
    reg clk;
    reg rst;
    reg ce;
    wire psel, penable, pwrite, pready, pslverr, lo, hi, done, adc_n, dac_n, clr_n;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [1:0] dsf, ratio, state;
    integer fails;
    integer n_tests;
    reg [31:0] rd;
    reg err;
    reg ok;
    adpbs_top #(.PLL_WAIT_CYCLES(PLL_WAIT_CYCLES)) DUT (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .CLOCK_RATIO_SEL_LO_IN(lo), .CLOCK_RATIO_SEL_HI_IN(hi), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .INIT_DONE_OUT(done), .ADC_MUTE_N_OUT(adc_n), .DAC_MUTE_N_OUT(dac_n),
        .CLEAR_REGS_N_OUT(clr_n), .DAC_SETUP_FIELD_OUT(dsf), .CLOCK_RATIO_OUT(ratio), .SEQ_STATE_OUT(state));
    adpbs_host host (.clk_in(clk), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata), .ratio_lo_out(lo), .ratio_hi_out(hi));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    // Refused reads return zero, so one expectation fits both
    task acc(input w, input [11:0] a, input [31:0] d, input [31:0] exp, input eerr);
    begin
        host.xfer(w, a, d, rd, err, ok);
        if (!ok)
        begin
            fails = fails + 1;
            end_sim;
        end
        chk({31'h0, err}, {31'h0, eerr});
        if (!w)
            chk(rd, exp);
    end
    endtask
    task t_boot(input [1:0] code, input [31:0] mult, input integer hold);
        integer n;
        time t0;
    begin
        rst <= 1'b1;
        host.set_ratio(code);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t0 = $time;
        acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
        // Frozen cycles must not count towards start-up
        if (hold > 0)
        begin
            ce <= 1'b0;
            repeat (hold) @(posedge clk);
            ce <= 1'b1;
        end
        for (n = 0; n < 5000 && done !== 1'b1; n = n + 1)
            @(posedge clk);
        if (done !== 1'b1)
        begin
            fails = fails + 1;
            end_sim;
        end
        n = ($time - t0) / 25;
        chk(n >= PLL_WAIT_CYCLES + 1680 + hold && n <= PLL_WAIT_CYCLES + 2210 + hold, 32'h1);
        chk(ratio, code);
        chk(state, 32'h3);
        chk({adc_n, dac_n, clr_n, dsf}, 32'h0);
        acc(1'b0, 12'h008, 32'h0, {27'h0, 2'h3, code, 1'b1}, 1'b0);
        acc(1'b0, 12'h00c, 32'h0, mult, 1'b0);
        $display("t_boot %0d done", code);
    end
    endtask
    task t_mem;
        integer i;
    begin
        acc(1'b1, 12'h010, 32'h0, 32'h0, 1'b0);
        for (i = 0; i < 7; i = i + 1)
            acc(1'b0, 12'h014, 32'h0, BOOT[32 * i +: 32], 1'b0);
        acc(1'b1, 12'h010, 32'h3ff, 32'h0, 1'b0);
        acc(1'b0, 12'h014, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h014, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 12'h010, 32'h400, 32'h0, 1'b0);
        acc(1'b0, 12'h014, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h018, 32'h0, 32'h0, 1'b1);
        acc(1'b1, 12'h008, 32'h5, 32'h0, 1'b1);
        $display("t_mem done");
    end
    endtask
    task t_init;
    begin
        host.bring_up(ok);
        chk({31'h0, ok}, 32'h1);
        repeat (2) @(posedge clk);
        chk({adc_n, dac_n, clr_n, dsf}, 32'h1d);
        acc(1'b0, 12'h000, 32'h0, 32'h1c, 1'b0);
        acc(1'b1, 12'h010, 32'h400, 32'h0, 1'b0);
        acc(1'b0, 12'h014, 32'h0, 32'h0, 1'b0);
        acc(1'b1, 12'h010, 32'h5, 32'h0, 1'b0);
        acc(1'b1, 12'h014, 32'h5a5a0f0f, 32'h0, 1'b0);
        acc(1'b1, 12'h010, 32'h5, 32'h0, 1'b0);
        acc(1'b0, 12'h014, 32'h0, 32'h5a5a0f0f, 1'b0);
        // Deliberate pin change while running
        host.set_ratio(2'h0);
        repeat (4) @(posedge clk);
        chk(ratio, 32'h3);
        $display("t_init done");
    end
    endtask
    // Reset after unmute and a program write must restore defaults
    task t_reboot;
    begin
        t_boot(2'h1, 32'h100, 0);
        acc(1'b1, 12'h010, 32'h5, 32'h0, 1'b0);
        acc(1'b0, 12'h014, 32'h0, BOOT[32 * 5 +: 32], 1'b0);
        $display("t_reboot done");
    end
    endtask
    initial
    begin
        fails = 0;
        n_tests = 0;
        ce <= 1'b1;
        t_boot(2'h0, 32'h40, 0);
        t_boot(2'h1, 32'h100, 100);
        t_boot(2'h2, 32'h180, 0);
        t_boot(2'h3, 32'h200, 0);
        t_mem;
        t_init;
        t_reboot;
        end_sim;
    end
endmodule // tb_top
bind adpbs_top adpbs_chk #(.PLL_WAIT_CYCLES(PLL_WAIT_CYCLES)) u_chk (.*);
